/* File: logic/mps_pkg.sv */
// Package for the motor drive protection supervisor.
// Assumes one 100 MHz system clock and a plain register port.
package mps_pkg;

    // Register byte addresses (word index times four)
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_CLEAR    = 8'h08;
    localparam logic [7:0] ADDR_IRQ_EN   = 8'h0C;
    localparam logic [7:0] ADDR_CUR_LIM  = 8'h10;
    localparam logic [7:0] ADDR_TEMP_LIM = 8'h14;
    localparam logic [7:0] ADDR_DER_TEMP = 8'h18;
    localparam logic [7:0] ADDR_SPD_MAX  = 8'h1C;
    localparam logic [7:0] ADDR_SPD_BRK  = 8'h20;
    localparam logic [7:0] ADDR_VBUS_MAX = 8'h24;
    localparam logic [7:0] ADDR_TIMEOUT  = 8'h28;
    localparam logic [7:0] ADDR_STATE    = 8'h2C;

    // Control register fields
    localparam int CTRL_OC_LATCH = 0;
    localparam int CTRL_OT_LATCH = 1;
    localparam int CTRL_ARM      = 2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // Status bit positions
    localparam int ST_OC      = 0;
    localparam int ST_OT      = 1;
    localparam int ST_DERATE  = 2;
    localparam int ST_OVSPD   = 3;
    localparam int ST_REGEN   = 4;
    localparam int ST_TIMEOUT = 5;
    localparam int ST_WDOG    = 6;
    localparam int ST_W       = 7;

    // Limit reset values
    localparam logic [15:0] CUR_LIM_RST  = 16'h0FFF;
    localparam logic [15:0] TEMP_LIM_RST = 16'h0FFF;
    localparam logic [15:0] DER_TEMP_RST = 16'h0E00;
    localparam logic [15:0] SPD_MAX_RST  = 16'h7FFF;
    localparam logic [15:0] SPD_BRK_RST  = 16'hFFFF;
    localparam logic [15:0] VBUS_MAX_RST = 16'hFFFF;
    localparam logic [31:0] TIMEOUT_RST  = 32'h000F_4240;

    // Watchdog: time in microseconds, cycles derived from 100 MHz
    localparam int CLK_MHZ     = 100;
    localparam int WDOG_US     = 10_000;
    localparam int WDOG_CYCLES = WDOG_US * CLK_MHZ;
    localparam int REBOOT_CYCLES = 16;

    // Drive modes
    typedef enum logic [1:0] {
        MPS_DRIVE = 2'b00,
        MPS_OFF   = 2'b01,
        MPS_BRAKE = 2'b10,
        MPS_COAST = 2'b11
    } mps_mode_e;

    // Sensor sample bundle
    typedef struct packed {
        logic [15:0] current;
        logic [15:0] ctl_temp;
        logic [15:0] coil_temp;
        logic [15:0] speed;
        logic [15:0] vbus;
    } mps_sense_s;

endpackage : mps_pkg

/* File: logic/mps_top.sv */
// Protection supervisor: limits drive voltage and trips the bridge.
// Assumes synchronous sensor samples, a one-cycle valid command pulse
// and a firmware heartbeat pulse for the watchdog.
//
// Function
// - Clamp commanded voltage so predicted current stays below the limit.
// - On measured over-current switch every bridge switch off.
// - Control bit selects latching or non-latching over-current trip.
// - Latched trip keeps bridge off until host clears the flag.
// - Non-latching trip re-enables as soon as current is below limit.
// - Both trips reset to non-latching.
// - Near max controller temperature derate voltage, still giving allowed power.
// - Derate ends by itself when temperature falls.
// - Same derate applies to estimated coil temperature.
// - On measured over-temperature switch every bridge switch off.
// - Thermal trip has own latch select; non-latching recovers at once.
// - Above max speed reduce voltage, more the farther above.
// - At extreme overspeed brake by shorting all phases.
// - Limit voltage when regenerated supply exceeds its range.
// - No valid command within timeout disarms and coasts.
// - New valid command after timeout resumes normal operation.
// - Frozen controller makes watchdog reboot to disarmed state.

`timescale 1ns/1ps

module mps_top (
    // Clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rst_b,
    // Register port
    input  wire logic [7:0]          reg_addr,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [31:0]         reg_rdata,
    // Sensors and commands
    input  wire mps_pkg::mps_sense_s sense,
    input  wire logic                cmd_valid,
    input  wire logic [15:0]         cmd_volt,
    input  wire logic                heartbeat,
    // Bridge and status
    output logic [15:0]              drive_volt,
    output mps_pkg::mps_mode_e       drive_mode,
    output logic                     armed,
    output logic                     reboot,
    output logic                     irq
);

    ////////////////////////////////////////////////////////////////////
    // Registers

    logic [31:0]              ctrl;
    logic [15:0]              cur_lim;
    logic [15:0]              temp_lim;
    logic [15:0]              der_temp;
    logic [15:0]              spd_max;
    logic [15:0]              spd_brk;
    logic [15:0]              vbus_max;
    logic [31:0]              timeout;
    logic [mps_pkg::ST_W-1:0] status;
    logic [mps_pkg::ST_W-1:0] irq_en;
    logic [31:0]              to_cnt;
    logic                     timed_out;
    logic                     oc_trip;
    logic                     ot_trip;
    logic [31:0]              wd_cnt;
    logic [4:0]               rb_cnt;
    logic                     wd_fire;

    // Live conditions
    logic oc_now;
    logic ot_now;
    logic der_now;
    logic ovspd_now;
    logic brake_now;
    logic regen_now;
    logic clr_wr;
    logic [mps_pkg::ST_W-1:0] clr_bits;
    logic [mps_pkg::ST_W-1:0] set_bits;

    assign oc_now    = sense.current >= cur_lim;
    assign ot_now    = (sense.ctl_temp >= temp_lim) || (sense.coil_temp >= temp_lim);
    assign der_now   = (sense.ctl_temp >= der_temp) || (sense.coil_temp >= der_temp);
    assign ovspd_now = sense.speed > spd_max;
    assign brake_now = sense.speed >= spd_brk;
    assign regen_now = sense.vbus > vbus_max;
    assign clr_wr    = reg_wr && (reg_addr == mps_pkg::ADDR_CLEAR);
    assign clr_bits  = clr_wr ? reg_wdata[mps_pkg::ST_W-1:0] : '0;

    // Configuration writes; a reboot restores every default
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctrl     <= mps_pkg::CTRL_RESET;
            cur_lim  <= mps_pkg::CUR_LIM_RST;
            temp_lim <= mps_pkg::TEMP_LIM_RST;
            der_temp <= mps_pkg::DER_TEMP_RST;
            spd_max  <= mps_pkg::SPD_MAX_RST;
            spd_brk  <= mps_pkg::SPD_BRK_RST;
            vbus_max <= mps_pkg::VBUS_MAX_RST;
            timeout  <= mps_pkg::TIMEOUT_RST;
            irq_en   <= '0;
        end else if (wd_fire) begin
            ctrl     <= mps_pkg::CTRL_RESET;
            cur_lim  <= mps_pkg::CUR_LIM_RST;
            temp_lim <= mps_pkg::TEMP_LIM_RST;
            der_temp <= mps_pkg::DER_TEMP_RST;
            spd_max  <= mps_pkg::SPD_MAX_RST;
            spd_brk  <= mps_pkg::SPD_BRK_RST;
            vbus_max <= mps_pkg::VBUS_MAX_RST;
            timeout  <= mps_pkg::TIMEOUT_RST;
            irq_en   <= '0;
        end else if (reg_wr) begin
            case (reg_addr)
                mps_pkg::ADDR_CTRL:     ctrl     <= reg_wdata;
                mps_pkg::ADDR_IRQ_EN:   irq_en   <= reg_wdata[mps_pkg::ST_W-1:0];
                mps_pkg::ADDR_CUR_LIM:  cur_lim  <= reg_wdata[15:0];
                mps_pkg::ADDR_TEMP_LIM: temp_lim <= reg_wdata[15:0];
                mps_pkg::ADDR_DER_TEMP: der_temp <= reg_wdata[15:0];
                mps_pkg::ADDR_SPD_MAX:  spd_max  <= reg_wdata[15:0];
                mps_pkg::ADDR_SPD_BRK:  spd_brk  <= reg_wdata[15:0];
                mps_pkg::ADDR_VBUS_MAX: vbus_max <= reg_wdata[15:0];
                mps_pkg::ADDR_TIMEOUT:  timeout  <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                mps_pkg::ADDR_CTRL:     reg_rdata <= ctrl;
                mps_pkg::ADDR_STATUS:   reg_rdata <= {25'h0, status};
                mps_pkg::ADDR_IRQ_EN:   reg_rdata <= {25'h0, irq_en};
                mps_pkg::ADDR_CUR_LIM:  reg_rdata <= {16'h0, cur_lim};
                mps_pkg::ADDR_TEMP_LIM: reg_rdata <= {16'h0, temp_lim};
                mps_pkg::ADDR_DER_TEMP: reg_rdata <= {16'h0, der_temp};
                mps_pkg::ADDR_SPD_MAX:  reg_rdata <= {16'h0, spd_max};
                mps_pkg::ADDR_SPD_BRK:  reg_rdata <= {16'h0, spd_brk};
                mps_pkg::ADDR_VBUS_MAX: reg_rdata <= {16'h0, vbus_max};
                mps_pkg::ADDR_TIMEOUT:  reg_rdata <= timeout;
                mps_pkg::ADDR_STATE:    reg_rdata <= {26'h0, oc_trip, ot_trip,
                                                      timed_out, armed, drive_mode};
                default:                reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sticky flags: set wins over a clear in the same cycle

    always_comb begin
        set_bits = '0;
        set_bits[mps_pkg::ST_OC]      = oc_now;
        set_bits[mps_pkg::ST_OT]      = ot_now;
        set_bits[mps_pkg::ST_DERATE]  = der_now;
        set_bits[mps_pkg::ST_OVSPD]   = ovspd_now;
        set_bits[mps_pkg::ST_REGEN]   = regen_now;
        set_bits[mps_pkg::ST_TIMEOUT] = timed_out;
        set_bits[mps_pkg::ST_WDOG]    = wd_fire;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            status <= '0;
        end else begin
            status <= (status & ~clr_bits) | set_bits;
        end
    end

    // Level interrupt from enabled flags
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |((((status & ~clr_bits) | set_bits)) & irq_en);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Reactive trips; latched ones hold until the flag is cleared

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            oc_trip <= 1'b0;
        end else if (oc_now) begin
            oc_trip <= 1'b1;
        end else if (!ctrl[mps_pkg::CTRL_OC_LATCH]) begin
            oc_trip <= 1'b0;
        end else if (clr_bits[mps_pkg::ST_OC]) begin
            oc_trip <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ot_trip <= 1'b0;
        end else if (ot_now) begin
            ot_trip <= 1'b1;
        end else if (!ctrl[mps_pkg::CTRL_OT_LATCH]) begin
            ot_trip <= 1'b0;
        end else if (clr_bits[mps_pkg::ST_OT]) begin
            ot_trip <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Command timeout, restarted by every valid command

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            to_cnt    <= '0;
            timed_out <= 1'b0;
        end else if (cmd_valid || wd_fire) begin
            to_cnt    <= '0;
            timed_out <= 1'b0;
        end else if (to_cnt >= timeout) begin
            timed_out <= 1'b1;
        end else begin
            to_cnt <= to_cnt + 32'h0000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Watchdog: firmware heartbeat must arrive within the window

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wd_cnt  <= '0;
            wd_fire <= 1'b0;
        end else if (heartbeat || wd_fire) begin
            wd_cnt  <= '0;
            wd_fire <= 1'b0;
        end else if (wd_cnt == 32'(mps_pkg::WDOG_CYCLES - 1)) begin
            wd_cnt  <= '0;
            wd_fire <= 1'b1;
        end else begin
            wd_cnt <= wd_cnt + 32'h0000_0001;
        end
    end

    // Reboot pulse stretched so the controller restarts its startup
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rb_cnt <= '0;
            reboot <= 1'b0;
        end else if (wd_fire) begin
            rb_cnt <= 5'(mps_pkg::REBOOT_CYCLES);
            reboot <= 1'b1;
        end else if (rb_cnt != 5'h00) begin
            rb_cnt <= rb_cnt - 5'h01;
            reboot <= (rb_cnt != 5'h01);
        end
    end

    // Arming: follows the ARM bit outside a timeout; a reboot clears that bit, so it stays off
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            armed <= 1'b0;
        end else if (wd_fire || timed_out) begin
            armed <= 1'b0;
        end else begin
            armed <= ctrl[mps_pkg::CTRL_ARM];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Voltage limiter: limits apply in turn, each acting on the result of the one before

    logic [15:0] v_lim;
    logic [15:0] ovs_excess;
    always_comb begin
        v_lim = cmd_volt;
        // Predictive current clamp: headroom to the current limit
        if (v_lim > cur_lim - (cur_lim >> 3)) begin
            v_lim = cur_lim - (cur_lim >> 3);
        end
        // Derate halves output while hot, still delivering what fits
        if (der_now) begin
            v_lim = v_lim >> 1;
        end
        // Overspeed: subtract a penalty growing with the excess
        ovs_excess = ovspd_now ? (sense.speed - spd_max) : 16'h0000;
        if (ovs_excess >= v_lim) begin
            v_lim = 16'h0000;
        end else begin
            v_lim = v_lim - ovs_excess;
        end
        // Regen: quarter voltage so the motor generates less
        if (regen_now) begin
            v_lim = v_lim >> 2;
        end
    end

    // Mode and voltage to the bridge, priority off, brake, coast
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            drive_mode <= mps_pkg::MPS_COAST;
            drive_volt <= '0;
        end else if (oc_now || ot_now || oc_trip || ot_trip) begin
            drive_mode <= mps_pkg::MPS_OFF;
            drive_volt <= '0;
        end else if (brake_now) begin
            drive_mode <= mps_pkg::MPS_BRAKE;
            drive_volt <= '0;
        end else if (!armed || timed_out || wd_fire) begin
            drive_mode <= mps_pkg::MPS_COAST;
            drive_volt <= '0;
        end else begin
            drive_mode <= mps_pkg::MPS_DRIVE;
            drive_volt <= v_lim;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    oc_off_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        oc_now |=> drive_mode == mps_pkg::MPS_OFF)
        else $error("bridge not off after over-current");
    ot_off_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ot_now |=> drive_mode == mps_pkg::MPS_OFF && drive_volt == 16'h0000)
        else $error("bridge not off after over-temperature");
    oc_latch_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        oc_trip && ctrl[mps_pkg::CTRL_OC_LATCH] && !clr_bits[mps_pkg::ST_OC] |=> oc_trip)
        else $error("latched trip released without clear");
    oc_unlatch_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !oc_now && !ctrl[mps_pkg::CTRL_OC_LATCH] |=> !oc_trip)
        else $error("non-latching trip held");
    ot_unlatch_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !ot_now && !ctrl[mps_pkg::CTRL_OT_LATCH] |=> !ot_trip)
        else $error("non-latching thermal trip held");
    brake_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        brake_now && !oc_now && !ot_now && !oc_trip && !ot_trip
        |=> drive_mode == mps_pkg::MPS_BRAKE)
        else $error("no brake at extreme overspeed");
    timeout_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        timed_out |=> drive_mode != mps_pkg::MPS_DRIVE && !armed)
        else $error("driving after timeout");
    cmd_restart_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        cmd_valid |=> to_cnt == 32'h0 && !timed_out)
        else $error("command did not restart timeout");
    drive_lim_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        drive_volt <= $past(cur_lim))
        else $error("drive voltage above current limit");
    wdog_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        wd_fire |=> !armed && reboot && ctrl == mps_pkg::CTRL_RESET)
        else $error("watchdog did not reboot to disarmed");
    ot_latch_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ot_trip && ctrl[mps_pkg::CTRL_OT_LATCH] && !clr_bits[mps_pkg::ST_OT] |=> ot_trip)
        else $error("latched thermal trip released without clear");
    cmd_resume_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        timed_out && cmd_valid |=> !timed_out)
        else $error("command did not end timeout");

    // Each limit may only lower the voltage taken from the command
    derate_lim_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        der_now |=> drive_volt <= ($past(cmd_volt) >> 1))
        else $error("derate did not halve voltage");
    ovspd_lim_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ovspd_now |=> drive_volt < $past(cmd_volt) || drive_volt == 16'h0000)
        else $error("overspeed did not lower voltage");
    regen_lim_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        regen_now |=> drive_volt <= ($past(cmd_volt) >> 2))
        else $error("regen did not limit voltage");
    irq_level_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        1'b1 |=> irq == |(status & $past(irq_en)))
        else $error("interrupt level wrong");

endmodule : mps_top

/* File: tb/mps_host_model.sv */
// Host model: sends drive commands and firmware heartbeat pulses.
// Assumes the bench owns reset and chooses the command voltage level.
`timescale 1ns/1ps

module mps_host_model (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // Bench control
    input  wire logic        send_en,
    input  wire logic [15:0] volt_req,
    // Toward the supervisor
    output logic             cmd_valid,
    output logic [15:0]      cmd_volt,
    output logic             heartbeat
);
    logic [4:0] gap;

    // One command every 32 cycles; a pause is made by dropping send_en
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            gap       <= 5'h00;
            cmd_valid <= 1'b0;
            heartbeat <= 1'b0;
        end else begin
            gap       <= gap + 5'h01;
            cmd_valid <= send_en && (gap == 5'h1F);
            heartbeat <= (gap == 5'h0F); // Keeps the watchdog from firing
        end
    end

    // Requested voltage is a held level, as the supervisor expects
    assign cmd_volt = volt_req;
endmodule : mps_host_model

/* File: tb/mps_top_tb.sv */
// Testbench for the protection supervisor: register tasks and scenarios.
// Assumes the host model supplies commands and heartbeat pulses.
`timescale 1ns/1ps

module mps_top_tb;
    logic                clk_sys;
    logic                rst_b;
    logic [7:0]          reg_addr;
    logic [31:0]         reg_wdata;
    logic                reg_wr;
    logic                reg_rd;
    logic [31:0]         reg_rdata;
    logic [31:0]         rd_d;
    mps_pkg::mps_sense_s sense;
    logic                cmd_valid;
    logic [15:0]         cmd_volt;
    logic                heartbeat;
    logic [15:0]         drive_volt;
    mps_pkg::mps_mode_e  drive_mode;
    logic                armed;
    logic                reboot;
    logic                irq;
    logic                send_en;
    logic [15:0]         volt_req;
    int                  fail_count = 0;
    int                  comparisons = 0;
    int                  cycles = 0;

    mps_top i_mps_top (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sense(sense), .cmd_valid(cmd_valid), .cmd_volt(cmd_volt), .heartbeat(heartbeat),
        .drive_volt(drive_volt), .drive_mode(drive_mode), .armed(armed),
        .reboot(reboot), .irq(irq));

    mps_host_model i_mps_host_model (.clk_sys(clk_sys), .rst_b(rst_b), .send_en(send_en),
        .volt_req(volt_req), .cmd_valid(cmd_valid), .cmd_volt(cmd_volt),
        .heartbeat(heartbeat));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard; the scenarios need well under 20000 cycles
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count = fail_count + 1;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register port tasks and comparison helpers
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask : wr

    // Data stand only in the cycle after the strobe; taken at the edge ending it
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        @(posedge clk_sys);
        rd_d = reg_rdata;
    endtask : rd

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Lets a sense change pass the output register, compares values settled before the edge
    task automatic out(input mps_pkg::mps_mode_e m, input logic [15:0] v);
        repeat (4) @(posedge clk_sys);
        chk("drive_mode", {30'h0, drive_mode}, {30'h0, m});
        if (m == mps_pkg::MPS_DRIVE) begin
            chk("drive_volt", {16'h0, drive_volt}, {16'h0, v});
        end
    endtask : out

    task automatic flag(input string what, input int b);
        rd(mps_pkg::ADDR_STATUS);
        chk(what, {31'h0, rd_d[b]}, 32'h1);
    endtask : flag

    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    initial begin
        rst_b     = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 32'h0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        sense     = '0;
        send_en   = 1'b0;
        volt_req  = 16'h0400;
        repeat (12) @(posedge clk_sys);
        chk("reset mode", {30'h0, drive_mode}, {30'h0, mps_pkg::MPS_COAST});
        rst_b <= 1'b1;
        rd(mps_pkg::ADDR_CTRL);
        chk("ctrl reset", rd_d, mps_pkg::CTRL_RESET);
        rd(mps_pkg::ADDR_CUR_LIM);
        chk("cur_lim reset", rd_d, {16'h0, mps_pkg::CUR_LIM_RST});
        rd(mps_pkg::ADDR_TIMEOUT);
        chk("timeout reset", rd_d, mps_pkg::TIMEOUT_RST);
        wr(mps_pkg::ADDR_STATUS, 32'h7F);
        rd(mps_pkg::ADDR_STATUS);
        chk("status read only", rd_d, 32'h0);
        rd(mps_pkg::ADDR_CLEAR);
        chk("clear reads zero", rd_d, 32'h0);
        rd(8'hFC);
        chk("unmapped read", rd_d, 32'h0);
        $display("test registers done");

        // Arm and check the predictive current clamp
        send_en <= 1'b1;
        wr(mps_pkg::ADDR_CUR_LIM, 32'h0800);
        wr(mps_pkg::ADDR_CTRL, 32'h4);
        out(mps_pkg::MPS_DRIVE, 16'h0400);
        chk("armed", {31'h0, armed}, 32'h1);
        volt_req <= 16'h0FFF;
        out(mps_pkg::MPS_DRIVE, 16'h0700);
        volt_req <= 16'h0400;
        $display("test clamp done");

        // Derate on either temperature, leaving on its own
        sense.ctl_temp <= 16'h0E80;
        out(mps_pkg::MPS_DRIVE, 16'h0200);
        flag("derate flag", mps_pkg::ST_DERATE);
        sense.ctl_temp <= 16'h0000;
        out(mps_pkg::MPS_DRIVE, 16'h0400);
        sense.coil_temp <= 16'h0E80;
        out(mps_pkg::MPS_DRIVE, 16'h0200);
        sense.coil_temp <= 16'h0000;
        $display("test derate done");

        // Thermal trip, non-latching then latching; interrupt still masked
        sense.ctl_temp <= 16'h1000;
        out(mps_pkg::MPS_OFF, 16'h0000);
        chk("irq masked", {31'h0, irq}, 32'h0);
        flag("ot flag", mps_pkg::ST_OT);
        sense.ctl_temp <= 16'h0000;
        out(mps_pkg::MPS_DRIVE, 16'h0400);
        wr(mps_pkg::ADDR_CTRL, 32'h6);
        sense.coil_temp <= 16'h1000;
        out(mps_pkg::MPS_OFF, 16'h0000);
        sense.coil_temp <= 16'h0000;
        out(mps_pkg::MPS_OFF, 16'h0000);
        wr(mps_pkg::ADDR_CLEAR, 32'h2);
        out(mps_pkg::MPS_DRIVE, 16'h0400);
        wr(mps_pkg::ADDR_CTRL, 32'h4);
        $display("test thermal trip done");

        // Current trip with the interrupt enabled, then latching
        wr(mps_pkg::ADDR_IRQ_EN, 32'h1);
        sense.current <= 16'h0900;
        out(mps_pkg::MPS_OFF, 16'h0000);
        chk("irq raised", {31'h0, irq}, 32'h1);
        sense.current <= 16'h0000;
        out(mps_pkg::MPS_DRIVE, 16'h0400);
        chk("irq sticky", {31'h0, irq}, 32'h1);
        wr(mps_pkg::ADDR_CLEAR, 32'h1);
        out(mps_pkg::MPS_DRIVE, 16'h0400);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        wr(mps_pkg::ADDR_CTRL, 32'h5);
        sense.current <= 16'h0900;
        out(mps_pkg::MPS_OFF, 16'h0000);
        sense.current <= 16'h0000;
        out(mps_pkg::MPS_OFF, 16'h0000);
        wr(mps_pkg::ADDR_CLEAR, 32'h1);
        out(mps_pkg::MPS_DRIVE, 16'h0400);
        wr(mps_pkg::ADDR_CTRL, 32'h4);
        $display("test current trip done");

        // Soft speed limit, brake, and supply limit
        wr(mps_pkg::ADDR_SPD_MAX, 32'h1000);
        wr(mps_pkg::ADDR_SPD_BRK, 32'h2000);
        sense.speed <= 16'h1010;
        out(mps_pkg::MPS_DRIVE, 16'h03F0);
        sense.speed <= 16'h1020;
        out(mps_pkg::MPS_DRIVE, 16'h03E0);
        flag("overspeed flag", mps_pkg::ST_OVSPD);
        sense.speed <= 16'h2000;
        out(mps_pkg::MPS_BRAKE, 16'h0000);
        sense.speed <= 16'h0000;
        wr(mps_pkg::ADDR_VBUS_MAX, 32'h1000);
        sense.vbus <= 16'h1100;
        out(mps_pkg::MPS_DRIVE, 16'h0100);
        flag("regen flag", mps_pkg::ST_REGEN);
        sense.vbus <= 16'h0000;
        $display("test speed and supply done");

        // Command timeout: steady commands hold it off, a pause trips it
        wr(mps_pkg::ADDR_TIMEOUT, 32'h64);
        repeat (300) @(posedge clk_sys);
        out(mps_pkg::MPS_DRIVE, 16'h0400);
        send_en <= 1'b0;
        repeat (150) @(posedge clk_sys);
        out(mps_pkg::MPS_COAST, 16'h0000);
        chk("disarmed", {31'h0, armed}, 32'h0);
        flag("timeout flag", mps_pkg::ST_TIMEOUT);
        rd(mps_pkg::ADDR_STATE);
        chk("state word", rd_d, 32'h0000_000B);
        send_en <= 1'b1;
        repeat (40) @(posedge clk_sys);
        out(mps_pkg::MPS_DRIVE, 16'h0400);
        chk("rearmed", {31'h0, armed}, 32'h1);
        $display("test timeout done");

        // Mid-run reset stands in for a reboot: motor idles until rearmed
        rst_b <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        out(mps_pkg::MPS_COAST, 16'h0000);
        chk("reboot idle", {31'h0, reboot}, 32'h0);
        chk("reset disarmed", {31'h0, armed}, 32'h0);
        wr(mps_pkg::ADDR_CUR_LIM, 32'h0800);
        wr(mps_pkg::ADDR_CTRL, 32'h4);
        out(mps_pkg::MPS_DRIVE, 16'h0400);
        $display("test reset rearm done");
        summarize();
    end
endmodule : mps_top_tb
